// ### hw/tcf_defs.vh
`ifndef TCF_DEFS_VH
`define TCF_DEFS_VH

// Register indices; the byte address is four times the index.
`define TCF_IDX_GRA 16'hFFF8
`define TCF_IDX_GRB 16'hFFFA
`define TCF_IDX_CTRL 16'hFFF0
`define TCF_IDX_STAT 16'hFFF2
`define TCF_IDX_CNT 16'hFFF3
`define TCF_IDX_IRQ_STAT 16'hFFF4
`define TCF_IDX_IRQ_EN 16'hFFF5
`define TCF_IDX_IRQ_CLR 16'hFFF6

// Reset values.
`define TCF_GR_RESET 16'hFFFF
`define TCF_CNT_RESET 16'h0000
`define TCF_CTRL_RESET 6'h00

// Control register fields.
`define TCF_CTRL_MODE_LSB 0
`define TCF_CTRL_MODE_MSB 2
`define TCF_CTRL_RSVD_MODE 3
`define TCF_CTRL_CASCADE 4
`define TCF_CTRL_CAPTURE_B 5

// Status register fields.
`define TCF_ST_FLAG_B 1
`define TCF_ST_OVF 4
`define TCF_ST_UNF 5
`define TCF_ST_ONE 6
`define TCF_ST_DIR 7

// Interrupt event bit positions.
`define TCF_EV_B 0
`define TCF_EV_OVF 1
`define TCF_EV_UNF 2
`define TCF_EV_W 3

// Phase counting modes have mode bit 2 set.
`define TCF_MODE_PHASE_BIT 2

// AXI responses.
`define TCF_RESP_OKAY 2'h0
`define TCF_RESP_SLVERR 2'h2

`endif

// ### hw/tcf_channel.v
`timescale 1ns/1ps
`include "tcf_defs.vh"

// Overview of operation
// (RULE_01) Flag B sets when the counter reaches register B in compare use.
// (RULE_02) Flag B sets when a capture strobe loads the counter into register B.
// (RULE_03) Flag B clears on a transfer controller start while its disable bit is zero.
// (RULE_04) Software clears flag B by writing zero after reading it as one.
// (RULE_05) Overflow flag sets when the counter wraps up from all ones to zero.
// (RULE_06) Only zero writes to flags act, and only to clear; ones are ignored.
// (RULE_07) Down counting is allowed only in phase counting or cascade counting.
// (RULE_08) In every other configuration every count tick counts upward.
// (RULE_09) Two 16-bit general registers A and B, each resetting to all ones.
// (RULE_10) Underflow flag sets on a downward wrap, cleared by read-then-write-zero.
// (RULE_11) Mode field selects normal, PWM or phase modes; top bit is reserved zero.
module tcf_channel #(
	parameter ADDR_W = 18,
	parameter CNT_W = 16
) (
	// Clock and reset.
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write channels.
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read channels.
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Count ticks and capture strobe from the channel.
	input wire count_up_tick,
	input wire count_down_tick,
	input wire capture_b_strobe,
	// Transfer controller handshake.
	input wire transfer_start_b,
	input wire transfer_irq_disable_select,
	// Channel outputs.
	output wire [CNT_W-1:0] channel_counter,
	output wire [2:0] channel_mode,
	output wire match_capture_irq_b,
	output wire irq
);

	function [15:0] word_idx;
		input [ADDR_W-1:0] a;
		begin
			word_idx = a[17:2];
		end
	endfunction

	function [15:0] lane_merge;
		input [15:0] old;
		input [31:0] d;
		input [3:0] s;
		begin
			lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
		end
	endfunction

	reg [CNT_W-1:0] counter_reg;
	reg [15:0] gra_reg;
	reg [15:0] grb_reg;
	reg [5:0] ctrl_reg;
	reg flag_b_reg;
	reg ovf_reg;
	reg unf_reg;
	reg dir_reg;
	reg arm_b_reg;
	reg arm_ovf_reg;
	reg arm_unf_reg;
	reg [`TCF_EV_W-1:0] irq_stat_reg;
	reg [`TCF_EV_W-1:0] irq_en_reg;
	reg aw_full_reg;
	reg w_full_reg;
	reg [15:0] aw_idx_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;

	// Write path: address and data are taken in either order.
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	wire aw_hs = s_axi_awvalid && s_axi_awready;
	wire w_hs = s_axi_wvalid && s_axi_wready;
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	wire wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
	wire [15:0] ar_idx = word_idx(s_axi_araddr);

	wire wr_gra = wr_fire && aw_idx_reg == `TCF_IDX_GRA;
	wire wr_grb = wr_fire && aw_idx_reg == `TCF_IDX_GRB;
	wire wr_ctrl = wr_fire && aw_idx_reg == `TCF_IDX_CTRL && w_strb_reg[0];
	wire wr_stat = wr_fire && aw_idx_reg == `TCF_IDX_STAT && w_strb_reg[0];
	wire wr_irq_en = wr_fire && aw_idx_reg == `TCF_IDX_IRQ_EN && w_strb_reg[0];
	wire wr_irq_clr = wr_fire && aw_idx_reg == `TCF_IDX_IRQ_CLR &&
		w_strb_reg[0];
	wire rd_stat = ar_hs && ar_idx == `TCF_IDX_STAT;

	function wr_known;
		input [15:0] i;
		begin
			wr_known = i == `TCF_IDX_GRA || i == `TCF_IDX_GRB ||
				i == `TCF_IDX_CTRL || i == `TCF_IDX_STAT ||
				i == `TCF_IDX_IRQ_EN || i == `TCF_IDX_IRQ_CLR;
		end
	endfunction

	// Counting direction and wrap detection.
	wire [2:0] mode = ctrl_reg[`TCF_CTRL_MODE_MSB:`TCF_CTRL_MODE_LSB];
	wire down_ok = mode[`TCF_MODE_PHASE_BIT] ||
		ctrl_reg[`TCF_CTRL_CASCADE]; // [RULE_07]
	wire tick = count_up_tick || count_down_tick;
	wire go_down = down_ok && count_down_tick && !count_up_tick;
	wire go_up = tick && !go_down; // [RULE_08]
	wire [CNT_W-1:0] all_ones = {CNT_W{1'b1}};
	wire [CNT_W-1:0] all_zero = {CNT_W{1'b0}};
	wire [CNT_W-1:0] cnt_next = go_down ? counter_reg - 1'b1 :
		(go_up ? counter_reg + 1'b1 : counter_reg);
	wire ev_ovf = go_up && counter_reg == all_ones; // [RULE_05]
	wire ev_unf = go_down && counter_reg == all_zero; // [RULE_10]
	wire capture_b = ctrl_reg[`TCF_CTRL_CAPTURE_B];
	wire ev_cmp_b = !capture_b && tick && cnt_next == grb_reg; // [RULE_01]
	wire ev_cap_b = capture_b && capture_b_strobe; // [RULE_02]
	wire ev_b = ev_cmp_b || ev_cap_b;
	wire dtc_clr_b = transfer_start_b && !transfer_irq_disable_select; // [RULE_03]

	// Zero-write clears need a prior read of one.
	wire sw_clr_b = wr_stat && !w_data_reg[`TCF_ST_FLAG_B] &&
		arm_b_reg; // [RULE_04] [RULE_06]
	wire sw_clr_ovf = wr_stat && !w_data_reg[`TCF_ST_OVF] &&
		arm_ovf_reg; // [RULE_06]
	wire sw_clr_unf = wr_stat && !w_data_reg[`TCF_ST_UNF] &&
		arm_unf_reg; // [RULE_10]

	wire [7:0] stat_word;
	assign stat_word = {dir_reg, 1'b1, unf_reg, ovf_reg, 2'b00,
		flag_b_reg, 1'b0};

	wire [`TCF_EV_W-1:0] ev_vec;
	assign ev_vec = {ev_unf, ev_ovf, ev_b};

	reg [31:0] rd_word;
	reg rd_ok;
	always @* begin
		rd_word = 32'h00000000;
		rd_ok = 1'b1;
		case (ar_idx)
			`TCF_IDX_GRA: rd_word = {16'h0000, gra_reg};
			`TCF_IDX_GRB: rd_word = {16'h0000, grb_reg};
			`TCF_IDX_CTRL: rd_word = {26'h0000000, ctrl_reg};
			`TCF_IDX_STAT: rd_word = {24'h000000, stat_word};
			`TCF_IDX_CNT: rd_word = {{(32-CNT_W){1'b0}}, counter_reg};
			`TCF_IDX_IRQ_STAT: rd_word = {29'h00000000, irq_stat_reg};
			`TCF_IDX_IRQ_EN: rd_word = {29'h00000000, irq_en_reg};
			`TCF_IDX_IRQ_CLR: rd_word = 32'h00000000;
			default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_idx_reg <= 16'h0000;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TCF_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `TCF_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
		end else begin
			if (aw_hs) begin
				aw_full_reg <= 1'b1;
				aw_idx_reg <= word_idx(s_axi_awaddr);
			end
			if (w_hs) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known(aw_idx_reg) ? `TCF_RESP_OKAY :
					`TCF_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (ar_hs) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_ok ? `TCF_RESP_OKAY : `TCF_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Channel state, flags and general registers.
	always @(posedge aclk) begin
		if (!aresetn) begin
			counter_reg <= `TCF_CNT_RESET;
			gra_reg <= `TCF_GR_RESET; // [RULE_09]
			grb_reg <= `TCF_GR_RESET; // [RULE_09]
			ctrl_reg <= `TCF_CTRL_RESET;
			flag_b_reg <= 1'b0;
			ovf_reg <= 1'b0;
			unf_reg <= 1'b0;
			dir_reg <= 1'b1;
			arm_b_reg <= 1'b0;
			arm_ovf_reg <= 1'b0;
			arm_unf_reg <= 1'b0;
			irq_stat_reg <= {`TCF_EV_W{1'b0}};
			irq_en_reg <= {`TCF_EV_W{1'b0}};
		end else begin
			counter_reg <= cnt_next;
			if (go_down)
				dir_reg <= 1'b0;
			else if (go_up)
				dir_reg <= 1'b1;
			if (wr_gra)
				gra_reg <= lane_merge(gra_reg, w_data_reg, w_strb_reg);
			if (ev_cap_b)
				grb_reg <= counter_reg; // [RULE_02]
			else if (wr_grb)
				grb_reg <= lane_merge(grb_reg, w_data_reg, w_strb_reg);
			if (wr_ctrl) begin
				ctrl_reg[2:0] <= w_data_reg[2:0]; // [RULE_11]
				ctrl_reg[`TCF_CTRL_RSVD_MODE] <= 1'b0; // [RULE_11]
				ctrl_reg[5:4] <= w_data_reg[5:4];
			end
			// Setting wins over any clear in the same cycle.
			if (ev_b)
				flag_b_reg <= 1'b1;
			else if (sw_clr_b || dtc_clr_b)
				flag_b_reg <= 1'b0; // [RULE_03] [RULE_04]
			if (ev_ovf)
				ovf_reg <= 1'b1; // [RULE_05]
			else if (sw_clr_ovf)
				ovf_reg <= 1'b0;
			if (ev_unf)
				unf_reg <= 1'b1; // [RULE_10]
			else if (sw_clr_unf)
				unf_reg <= 1'b0;
			// A read that returns one arms the later zero-write clear.
			if (rd_stat)
				arm_b_reg <= flag_b_reg; // [RULE_04]
			else if (sw_clr_b || dtc_clr_b || wr_stat)
				arm_b_reg <= 1'b0;
			if (rd_stat)
				arm_ovf_reg <= ovf_reg;
			else if (wr_stat)
				arm_ovf_reg <= 1'b0;
			if (rd_stat)
				arm_unf_reg <= unf_reg; // [RULE_10]
			else if (wr_stat)
				arm_unf_reg <= 1'b0;
			if (wr_irq_en)
				irq_en_reg <= w_data_reg[`TCF_EV_W-1:0];
			irq_stat_reg <= ev_vec | (irq_stat_reg &
				~(wr_irq_clr ? w_data_reg[`TCF_EV_W-1:0] :
				{`TCF_EV_W{1'b0}}));
		end
	end

	assign channel_counter = counter_reg;
	assign channel_mode = mode;
	assign match_capture_irq_b = flag_b_reg && irq_en_reg[`TCF_EV_B];
	assign irq = |(irq_stat_reg & irq_en_reg);

endmodule // tcf_channel

// ### testbench/tcf_channel_properties.sv
`timescale 1ns/1ps
module tcf_channel_props (
	// Clock and reset.
	input wire aclk,
	input wire aresetn,
	// Register bus.
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// Channel side.
	input wire count_up_tick,
	input wire count_down_tick,
	input wire capture_b_strobe,
	input wire transfer_start_b,
	input wire transfer_irq_disable_select,
	input wire [15:0] channel_counter,
	input wire [2:0] channel_mode,
	input wire match_capture_irq_b
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence quiet;
		!count_up_tick && !count_down_tick && !capture_b_strobe;
	endsequence
	up_count_a: assert property (
		count_up_tick |=> channel_counter == $past(channel_counter) + 16'h1)
		else $error("Up tick did not add one.");
	down_count_a: assert property (
		count_down_tick && !count_up_tick && channel_mode[2]
		|=> channel_counter == $past(channel_counter) - 16'h1)
		else $error("Down tick did not subtract one.");
	count_hold_a: assert property (
		quiet |=> $stable(channel_counter))
		else $error("Counter moved without a tick.");
	transfer_clear_a: assert property (
		quiet ##0 (transfer_start_b && !transfer_irq_disable_select)
		|=> !match_capture_irq_b)
		else $error("Transfer start left flag B set.");
	read_answer_a: assert property (ar_take |=> s_axi_rvalid)
		else $error("Read answer late.");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data dropped.");
	write_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid)
		else $error("Write response dropped.");
	write_refuse_a: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("Write taken while response pending.");
endmodule // tcf_channel_props
bind tcf_channel tcf_channel_props chk (.aclk, .aresetn, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.count_up_tick, .count_down_tick, .capture_b_strobe, .transfer_start_b,
	.transfer_irq_disable_select, .channel_counter, .channel_mode,
	.match_capture_irq_b);

// ### testbench/tcf_xfer_model.sv
`timescale 1ns/1ps
module tcf_xfer_model (
	// Clock, reset and request.
	input wire aclk,
	input wire aresetn,
	input wire irq_b,
	// Start strobe.
	output reg start = 1'b0
);
	reg seen = 1'b0;
	// One start per rising request, as the controller would serve it.
	always @(posedge aclk) begin
		seen <= irq_b & aresetn;
		start <= aresetn & irq_b & ~seen;
	end
endmodule // tcf_xfer_model

// ### testbench/tcf_channel_tb.sv
`timescale 1ns/1ps
`include "tcf_defs.vh"
`define A(i) {i,2'b00}
`define CHK(a,b) begin check_count++; if ((a) !== (b)) begin fails++; \
	$display("Error %0t got %h exp %h", $time, a, b); end end
module tcf_channel_tb;
	reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	reg s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	reg count_up_tick = 0, count_down_tick = 0, capture_b_strobe = 0;
	reg transfer_irq_disable_select = 1;
	reg [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	reg [31:0] s_axi_wdata = 0, d;
	reg [3:0] s_axi_wstrb = 4'hF;
	reg [1:0] r;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, match_capture_irq_b, irq, transfer_start_b;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [15:0] channel_counter;
	wire [2:0] channel_mode;
	int fails = 0, check_count = 0;
	always #2.5 aclk = ~aclk;
	tcf_channel DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_up_tick,
		.count_down_tick, .capture_b_strobe, .transfer_start_b,
		.transfer_irq_disable_select, .channel_counter, .channel_mode,
		.match_capture_irq_b, .irq);
	tcf_xfer_model xfer (.aclk, .aresetn, .irq_b(match_capture_irq_b),
		.start(transfer_start_b));
	task tally_and_finish;
		begin
			$display("Checks %0d errors %0d", check_count, fails);
			if (fails == 0 && check_count > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task wr(input [17:0] a, input [31:0] v);
		int n;
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= v;
			s_axi_awvalid <= 1;
			s_axi_wvalid <= 1;
			s_axi_bready <= 1;
			for (n = 0; n < 40; n++) begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 0;
				if (s_axi_wready) s_axi_wvalid <= 0;
				if (s_axi_bvalid) break;
			end
			r = s_axi_bresp;
			s_axi_bready <= 0;
			if (n == 40) begin fails++; tally_and_finish; end
		end
	endtask
	task rd(input [17:0] a);
		int n;
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1;
			s_axi_rready <= 1;
			for (n = 0; n < 40; n++) begin
				@(posedge aclk);
				if (s_axi_arready) s_axi_arvalid <= 0;
				if (s_axi_rvalid) break;
			end
			d = s_axi_rdata;
			r = s_axi_rresp;
			s_axi_rready <= 0;
			if (n == 40) begin fails++; tally_and_finish; end
		end
	endtask
	task tick(input u, input v);
		begin
			@(posedge aclk);
			count_up_tick <= u;
			count_down_tick <= v;
			@(posedge aclk);
			count_up_tick <= 0;
			count_down_tick <= 0;
			@(negedge aclk);
		end
	endtask
	task t_reset;
		begin
			rd(`A(`TCF_IDX_GRA)); `CHK(d, 32'h0000FFFF)
			rd(`A(`TCF_IDX_GRB)); `CHK(d, 32'h0000FFFF)
			rd(`A(`TCF_IDX_STAT)); `CHK(d, 32'h000000C0)
		end
	endtask
	task t_wrap;
		begin
			wr(`A(`TCF_IDX_CTRL), 32'h0000000C);
			rd(`A(`TCF_IDX_CTRL)); `CHK(d, 32'h00000004)
			`CHK(channel_mode, 3'h4)
			tick(0, 1); `CHK(channel_counter, 16'hFFFF)
			tick(1, 0); `CHK(channel_counter, 16'h0000)
			rd(`A(`TCF_IDX_STAT)); `CHK(d[1], 1'b1)
			`CHK(d[4], 1'b1)
			`CHK(d[5], 1'b1)
			`CHK(irq, 1'b0)
			wr(`A(`TCF_IDX_IRQ_EN), 32'h00000007);
			@(negedge aclk); `CHK(irq, 1'b1)
			`CHK(match_capture_irq_b, 1'b1)
			wr(`A(`TCF_IDX_STAT), 32'h000000FF);
			rd(`A(`TCF_IDX_STAT)); `CHK(d[5:1], 5'h19)
			wr(`A(`TCF_IDX_STAT), 32'h00000000);
			rd(`A(`TCF_IDX_STAT)); `CHK(d[5:1], 5'h00)
			wr(`A(`TCF_IDX_IRQ_CLR), 32'h00000007);
			@(negedge aclk); `CHK(irq, 1'b0)
		end
	endtask
	task t_capture;
		begin
			wr(`A(`TCF_IDX_CTRL), 32'h00000000);
			tick(0, 1); `CHK(channel_counter, 16'h0001)
			wr(`A(`TCF_IDX_CTRL), 32'h00000020);
			@(posedge aclk);
			capture_b_strobe <= 1;
			transfer_irq_disable_select <= 0;
			@(posedge aclk);
			capture_b_strobe <= 0;
			repeat (3) @(negedge aclk);
			`CHK(irq, 1'b1)
			rd(`A(`TCF_IDX_GRB)); `CHK(d, 32'h00000001)
			rd(`A(`TCF_IDX_STAT)); `CHK(d[1], 1'b0)
		end
	endtask
	task t_cascade;
		begin
			@(posedge aclk);
			transfer_irq_disable_select <= 1;
			wr(`A(`TCF_IDX_CTRL), 32'h00000010);
			`CHK(channel_mode, 3'h0)
			tick(0, 1); `CHK(channel_counter, 16'h0000)
			tick(1, 1); `CHK(channel_counter, 16'h0001)
			`CHK(match_capture_irq_b, 1'b1)
			wr(`A(`TCF_IDX_STAT), 32'h00000000);
			`CHK(r, `TCF_RESP_OKAY)
			rd(`A(`TCF_IDX_STAT)); `CHK(d[1], 1'b1)
			wr(`A(`TCF_IDX_STAT), 32'h00000000);
			rd(`A(`TCF_IDX_STAT)); `CHK(d[1], 1'b0)
		end
	endtask
	task t_bus;
		begin
			rd(18'h00000); `CHK(r, `TCF_RESP_SLVERR)
			wr(`A(`TCF_IDX_CNT), 32'h00001234);
			`CHK(r, `TCF_RESP_SLVERR)
		end
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_wrap;
		t_capture;
		t_cascade;
		t_bus;
		tally_and_finish;
	end
endmodule // tcf_channel_tb
